// ==== inc/boc_pkg.sv ====
/*
 * Shared constants for the overcurrent hiccup controller: sequencer states,
 * trip-level code layout and all timing figures converted to cycles.
 * Assumes a 50 MHz reference clock; every count derives from that rate.
 */
package boc_pkg;

    localparam int unsigned CLK_MHZ        = 50;

    // Delay from power-on or enable to the trip-level sample.
    localparam int unsigned POR_DLY_US     = 6800;
    localparam int unsigned POR_DLY_CYC    = POR_DLY_US * CLK_MHZ;

    // Each soft-start, real or dummy, climbs in equal steps.
    localparam int unsigned SS_TIME_US     = 6800;
    localparam int unsigned SS_STEPS       = 64;
    localparam int unsigned SS_STEP_CYC    =
        (SS_TIME_US * CLK_MHZ) / SS_STEPS;
    localparam logic [5:0]  SS_LAST_STEP   = 6'h3F;

    // Blanking after the low-side edge, a least time, rounded up.
    localparam int unsigned BLANK_NS       = 200;
    localparam int unsigned BLANK_CYC      =
        (BLANK_NS * CLK_MHZ + 999) / 1000;
    // Least width of a stretched or inserted low-side pulse, rounded up.
    localparam int unsigned MIN_LS_NS      = 425;
    localparam int unsigned MIN_LS_CYC     =
        (MIN_LS_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned ON_W           = 5;
    localparam logic [ON_W-1:0] BLANK_CNT  = ON_W'(BLANK_CYC);
    localparam logic [ON_W-1:0] MIN_LS_CNT = ON_W'(MIN_LS_CYC);
    localparam logic [1:0]  NARROW_LIMIT   = 2'h2;

    // Sample-and-hold: a counter drives the DAC until it meets the pin.
    localparam int unsigned CODE_W         = 8;
    localparam int unsigned SAMP_TIME_US   = 3400;
    localparam int unsigned SAMP_STEP_CYC  =
        (SAMP_TIME_US * CLK_MHZ) / (1 << CODE_W);
    // Code that stands for the voltage above which protection is off.
    localparam logic [CODE_W-1:0] OCP_OFF_CODE = 8'hB4;
    localparam logic [CODE_W-1:0] CODE_RST     = 8'h00;

    localparam int unsigned TMR_W          = 19;

    // Gray codes along the usual path.
    typedef enum logic [2:0] {
        BOC_OFF     = 3'h0,
        BOC_POR_DLY = 3'h1,
        BOC_SAMPLE  = 3'h3,
        BOC_SOFT    = 3'h2,
        BOC_RUN     = 3'h6,
        BOC_DUMMY1  = 3'h7,
        BOC_DUMMY2  = 3'h5
    } boc_state_e;

endpackage

// ==== inc/boc_lsm_if.sv ====
/*
 * Link between the retry sequencer and the low-side gate monitor.
 * Assumes both ends share ref_clk and its clock enable.
 */
`timescale 1ns/1ps
interface boc_lsm_if;
    logic pwm_low;
    logic pwm_high;
    logic cycle_tick;
    logic trip_cmp;
    logic sw_en;
    logic ocp_en;
    logic low_gate;
    logic high_gate;
    logic trip_hit;

    modport seq (
        output pwm_low, pwm_high, cycle_tick, trip_cmp, sw_en, ocp_en,
        input  low_gate, high_gate, trip_hit
    );
    modport mon (
        input  pwm_low, pwm_high, cycle_tick, trip_cmp, sw_en, ocp_en,
        output low_gate, high_gate, trip_hit
    );
endinterface

// ==== core/boc_lsm.sv ====
/*
 * Low-side gate monitor: drives both gates, blanks the start of each
 * low-side pulse, samples the trip comparator inside the window and
 * stretches or inserts a narrow low-side pulse every third period.
 * Assumes cycle_tick marks the start of each switching period.
 */
`timescale 1ns/1ps
module boc_lsm
    import boc_pkg::*;
(
    // Clock and control
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic ce,
    // Sequencer link
    boc_lsm_if.mon    lk
);

    logic [ON_W-1:0] on_r,      on_nxt;
    logic [1:0]      narrow_r,  narrow_nxt;
    logic            wide_r,    wide_nxt;
    logic            stretch_r, stretch_nxt;
    logic            low_r,     low_nxt;
    logic            high_r,    high_nxt;
    logic            trip_r,    trip_nxt;

    always_comb begin
        narrow_nxt  = narrow_r;
        wide_nxt    = wide_r;
        stretch_nxt = stretch_r;
        on_nxt      = on_r;
        if (lk.cycle_tick) begin
            wide_nxt = 1'b0;
            if (wide_r) begin
                narrow_nxt = 2'h0;
            end else if (narrow_r + 2'h1 == NARROW_LIMIT) begin
                // Two narrow periods behind us: force the third pulse.
                narrow_nxt  = 2'h0;
                stretch_nxt = lk.ocp_en;
            end else begin
                narrow_nxt = narrow_r + 2'h1;
            end
        end
        if (low_r) begin
            if (on_r != MIN_LS_CNT) begin
                on_nxt = on_r + ON_W'(1);
            end
            if (on_r >= MIN_LS_CNT - ON_W'(1)) begin
                wide_nxt    = 1'b1;
                stretch_nxt = 1'b0;
            end
        end else begin
            on_nxt = '0;
        end
        if (!lk.sw_en || !lk.ocp_en) begin
            stretch_nxt = 1'b0;
        end
        low_nxt  = lk.sw_en & (lk.pwm_low | stretch_r);
        // The high side never overlaps a forced low-side pulse.
        high_nxt = lk.sw_en & lk.pwm_high & ~low_nxt;
        // Window opens after blanking, closes when the low gate drops.
        // A forced pulse keeps it open, or it would never be watched.
        trip_nxt = lk.sw_en & lk.ocp_en & low_r & (lk.pwm_low | stretch_r)
                   & (on_r >= BLANK_CNT) & lk.trip_cmp;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            on_r      <= '0;
            narrow_r  <= 2'h0;
            wide_r    <= 1'b0;
            stretch_r <= 1'b0;
            low_r     <= 1'b0;
            high_r    <= 1'b0;
            trip_r    <= 1'b0;
        end else if (ce) begin
            on_r      <= on_nxt;
            narrow_r  <= narrow_nxt;
            wide_r    <= wide_nxt;
            stretch_r <= stretch_nxt;
            low_r     <= low_nxt;
            high_r    <= high_nxt;
            trip_r    <= trip_nxt;
        end
    end

    assign lk.low_gate  = low_r;
    assign lk.high_gate = high_r;
    assign lk.trip_hit  = trip_r;

endmodule

// ==== core/boc_top.sv ====
/*
 * Overcurrent protection and hiccup retry sequencer for a single-phase
 * synchronous buck controller, with the low-side gate monitor inside.
 * Assumes rst_n is the supply power-on reset, enable_ok is the enable pin
 * comparator, and the analog DAC doubles trip_code against the switch node.
 */
//
// Overview of operation
// - On a trip stop switching; retry with two dummy soft-starts, one real.
// - Retry sequence repeats without any limit while the short persists.
// - Trip-level sample starts only after reset release plus a fixed delay.
// - While sampling keep low gate off and source the programming current.
// - Sampled level kept in counter and DAC until a fresh post-shutdown sample.
// - Monitoring starts a blanking time after the low-gate rising edge.
// - Monitoring ends when the low gate drops; trip accepted anywhere inside.
// - Three narrow or missing low pulses: third is stretched or inserted.
// - Protection disabled also disables low-side stretching and insertion.
// - Trip when switch drop reaches twice the sampled programming voltage.
// - Sample above a fixed limit means protection disabled.
// - Missing programming resistor reads over range and disables protection.
// - Trip during real soft-start stops output, returns to first dummy.
// - Retry period lies between two and three soft-start durations.
// - Detection stays active in every real soft-start, start-up included.
// - With the short gone the next real soft-start completes normally.
// - No resampling during retries; only after disable and re-enable.
// - Every soft-start lasts fixed time in 64 equal reference steps; dummy ones here hold ss_ref_code at zero.
// - Enable pin low stops oscillator, holds gates low, re-arms start.
`timescale 1ns/1ps
module boc_top
    import boc_pkg::*;
#(
    parameter int unsigned POR_DLY_CYCLES = POR_DLY_CYC,
    parameter int unsigned SS_STEP_CYCLES = SS_STEP_CYC
)(
    // Clock, reset and clock enable
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire logic              ce,
    // Enable pin comparator and oscillator
    input  wire logic              enable_ok,
    input  wire logic              cycle_tick,
    // Internal PWM requests
    input  wire logic              pwm_low_req,
    input  wire logic              pwm_high_req,
    // Analog comparators
    input  wire logic              sample_met,
    input  wire logic              trip_cmp,
    // Gate drivers and programming pin
    output logic                   high_side_gate,
    output logic                   low_side_gate,
    output logic                   trip_program_current,
    // Status and analog controls
    output logic [CODE_W-1:0]      trip_code,
    output logic [5:0]             ss_ref_code,
    output logic                   osc_run,
    output logic                   overcurrent_guard_on,
    output logic                   in_regulation,
    output logic                   oc_event
);

    localparam logic [TMR_W-1:0] POR_LAST  = TMR_W'(POR_DLY_CYCLES - 1);
    localparam logic [TMR_W-1:0] STEP_LAST = TMR_W'(SS_STEP_CYCLES - 1);
    localparam logic [TMR_W-1:0] SAMP_LAST = TMR_W'(SAMP_STEP_CYC - 1);

    boc_state_e        st_r,   st_nxt;
    logic [TMR_W-1:0]  tmr_r,  tmr_nxt;
    logic [5:0]        step_r, step_nxt;
    logic [CODE_W-1:0] code_r, code_nxt;
    logic              ocp_r,  ocp_nxt;
    logic              ev_r,   ev_nxt;
    logic              prog_r, prog_nxt;
    logic [5:0]        ref_r,  ref_nxt;
    logic              osc_r,  osc_nxt;
    logic              reg_r,  reg_nxt;
    logic              step_end;
    logic              ramp_end;

    boc_lsm_if lk ();

    assign lk.pwm_low    = pwm_low_req;
    assign lk.pwm_high   = pwm_high_req;
    assign lk.cycle_tick = cycle_tick;
    assign lk.trip_cmp   = trip_cmp;
    // Gates may switch only in a real soft-start or regulation.
    assign lk.sw_en      = enable_ok
                           & ((st_r == BOC_SOFT) | (st_r == BOC_RUN));
    assign lk.ocp_en     = ocp_r;

    boc_lsm boc_lsm_i (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .ce      (ce),
        .lk      (lk.mon)
    );

    assign step_end = (tmr_r == STEP_LAST);
    assign ramp_end = step_end & (step_r == SS_LAST_STEP);

    always_comb begin
        st_nxt   = st_r;
        tmr_nxt  = tmr_r;
        step_nxt = step_r;
        code_nxt = code_r;
        ocp_nxt  = ocp_r;
        ev_nxt   = 1'b0;
        if (!enable_ok) begin
            // Shutdown re-arms the whole start, sample included.
            st_nxt   = BOC_OFF;
            tmr_nxt  = '0;
            step_nxt = 6'h00;
        end else begin
            case (st_r)
                BOC_OFF: begin
                    st_nxt  = BOC_POR_DLY;
                    tmr_nxt = '0;
                end
                BOC_POR_DLY: begin
                    if (tmr_r == POR_LAST) begin
                        st_nxt   = BOC_SAMPLE;
                        tmr_nxt  = '0;
                        code_nxt = CODE_RST;
                    end else begin
                        tmr_nxt = tmr_r + TMR_W'(1);
                    end
                end
                BOC_SAMPLE: begin
                    if (sample_met) begin
                        // The DAC has reached the pin: the code is held.
                        st_nxt   = BOC_SOFT;
                        ocp_nxt  = 1'b1;
                        tmr_nxt  = '0;
                        step_nxt = 6'h00;
                    end else if (code_r == OCP_OFF_CODE) begin
                        // Over range, or no resistor: protection stays off.
                        st_nxt   = BOC_SOFT;
                        ocp_nxt  = 1'b0;
                        tmr_nxt  = '0;
                        step_nxt = 6'h00;
                    end else if (tmr_r == SAMP_LAST) begin
                        tmr_nxt  = '0;
                        code_nxt = code_r + CODE_W'(1);
                    end else begin
                        tmr_nxt = tmr_r + TMR_W'(1);
                    end
                end
                BOC_SOFT: begin
                    if (lk.trip_hit) begin
                        st_nxt   = BOC_DUMMY1;
                        tmr_nxt  = '0;
                        step_nxt = 6'h00;
                        ev_nxt   = 1'b1;
                    end else if (ramp_end) begin
                        st_nxt   = BOC_RUN;
                        tmr_nxt  = '0;
                        step_nxt = 6'h00;
                    end else if (step_end) begin
                        tmr_nxt  = '0;
                        step_nxt = step_r + 6'h01;
                    end else begin
                        tmr_nxt = tmr_r + TMR_W'(1);
                    end
                end
                BOC_RUN: begin
                    if (lk.trip_hit) begin
                        st_nxt   = BOC_DUMMY1;
                        tmr_nxt  = '0;
                        step_nxt = 6'h00;
                        ev_nxt   = 1'b1;
                    end
                end
                BOC_DUMMY1, BOC_DUMMY2: begin
                    // Dummy ramps time out exactly like a real one.
                    if (ramp_end) begin
                        st_nxt   = (st_r == BOC_DUMMY1) ? BOC_DUMMY2
                                                        : BOC_SOFT;
                        tmr_nxt  = '0;
                        step_nxt = 6'h00;
                    end else if (step_end) begin
                        tmr_nxt  = '0;
                        step_nxt = step_r + 6'h01;
                    end else begin
                        tmr_nxt = tmr_r + TMR_W'(1);
                    end
                end
                default: begin
                    st_nxt   = BOC_OFF;
                    tmr_nxt  = '0;
                    step_nxt = 6'h00;
                end
            endcase
        end
    end

    // Registered outputs follow the next state so they align with it.
    always_comb begin
        prog_nxt = (st_nxt == BOC_POR_DLY) | (st_nxt == BOC_SAMPLE);
        osc_nxt  = (st_nxt != BOC_OFF);
        reg_nxt  = (st_nxt == BOC_RUN);
        case (st_nxt)
            BOC_SOFT: ref_nxt = step_nxt;
            BOC_RUN:  ref_nxt = SS_LAST_STEP;
            default:  ref_nxt = 6'h00;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_r   <= BOC_OFF;
            tmr_r  <= '0;
            step_r <= 6'h00;
            code_r <= CODE_RST;
            ocp_r  <= 1'b0;
            ev_r   <= 1'b0;
            prog_r <= 1'b0;
            ref_r  <= 6'h00;
            osc_r  <= 1'b0;
            reg_r  <= 1'b0;
        end else if (ce) begin
            st_r   <= st_nxt;
            tmr_r  <= tmr_nxt;
            step_r <= step_nxt;
            code_r <= code_nxt;
            ocp_r  <= ocp_nxt;
            ev_r   <= ev_nxt;
            prog_r <= prog_nxt;
            ref_r  <= ref_nxt;
            osc_r  <= osc_nxt;
            reg_r  <= reg_nxt;
        end
    end

    // The low gate driver is held off by the sequencer while sampling.
    assign low_side_gate        = lk.low_gate;
    assign high_side_gate       = lk.high_gate;
    assign trip_program_current = prog_r;
    assign trip_code            = code_r;
    assign ss_ref_code          = ref_r;
    assign osc_run              = osc_r;
    assign overcurrent_guard_on = ocp_r;
    assign in_regulation        = reg_r;
    assign oc_event             = ev_r;

endmodule

// ==== testbench/boc_top_asserts.sv ====
/*
 * Concurrent checks on the ports of boc_top, attached by bind.
 * Assumes ce stays high, so every clock edge advances the design.
 */
`timescale 1ns/1ps
module boc_top_asserts
    import boc_pkg::*;
#(
    parameter int unsigned POR_DLY_CYCLES = POR_DLY_CYC,
    parameter int unsigned SS_STEP_CYCLES = SS_STEP_CYC
)(
    // Clock, reset and clock enable
    input wire logic              ref_clk,
    input wire logic              rst_n,
    input wire logic              ce,
    // Enable and oscillator
    input wire logic              enable_ok,
    input wire logic              cycle_tick,
    // Requests and comparators
    input wire logic              pwm_low_req,
    input wire logic              pwm_high_req,
    input wire logic              sample_met,
    input wire logic              trip_cmp,
    // Design outputs
    input wire logic              high_side_gate,
    input wire logic              low_side_gate,
    input wire logic              trip_program_current,
    input wire logic [CODE_W-1:0] trip_code,
    input wire logic [5:0]        ss_ref_code,
    input wire logic              osc_run,
    input wire logic              overcurrent_guard_on,
    input wire logic              in_regulation,
    input wire logic              oc_event
);
    localparam int unsigned BLANK_MIN = BLANK_CYC;
    int unsigned lg_run_r;
    int unsigned lg_run_nxt;
    int unsigned por_cnt_r;
    int unsigned por_cnt_nxt;
    int unsigned step_cnt_r;
    int unsigned step_cnt_nxt;
    logic [5:0]  ss_prev_r;

    // The power-on counter saturates so a long regulation run cannot wrap it.
    always_comb begin
        lg_run_nxt = low_side_gate ? lg_run_r + 1 : 0;
        por_cnt_nxt = !enable_ok ? 0 : por_cnt_r + (por_cnt_r < 1000000);
        step_cnt_nxt = (ss_ref_code != ss_prev_r) ? 1 : step_cnt_r + 1;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            lg_run_r <= 0;
            por_cnt_r <= 0;
            step_cnt_r <= 0;
            ss_prev_r <= 6'h00;
        end else begin
            lg_run_r <= lg_run_nxt;
            por_cnt_r <= por_cnt_nxt;
            step_cnt_r <= step_cnt_nxt;
            ss_prev_r <= ss_ref_code;
        end
    end

    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    program_gate_a: assert property (
        trip_program_current |-> !low_side_gate && !high_side_gate)
        else $error("gate on while sampling");
    sample_delay_a: assert property (
        $changed(trip_code) && trip_code != CODE_RST && trip_program_current
        |-> por_cnt_r > POR_DLY_CYCLES) else $error("sample too early");
    code_hold_a: assert property (
        $changed(trip_code) && osc_run && $past(osc_run)
        |-> trip_program_current) else $error("trip code resampled");
    shut_off_a: assert property (
        oc_event |=> (!low_side_gate && !high_side_gate)[*8])
        else $error("gates on after trip");
    event_pulse_a: assert property (
        oc_event |-> ss_ref_code == 6'h00 ##1 !oc_event)
        else $error("trip event shape wrong");
    blank_window_a: assert property (
        oc_event |-> $past(lg_run_r, 2) >= BLANK_MIN)
        else $error("trip inside blanking");
    trip_react_a: assert property (
        trip_cmp && pwm_low_req && low_side_gate && lg_run_r >= 12 &&
        overcurrent_guard_on && enable_ok && !oc_event
        |-> ##[1:2] oc_event) else $error("trip missed");
    reg_full_a: assert property (
        in_regulation |-> ss_ref_code == SS_LAST_STEP)
        else $error("regulating below full scale");
    step_len_a: assert property (
        $changed(ss_ref_code) && ss_ref_code > 6'h01
        |-> step_cnt_r == SS_STEP_CYCLES) else $error("uneven step");
    shutdown_a: assert property (
        !enable_ok |-> ##1 !low_side_gate && !high_side_gate && !osc_run)
        else $error("switching while disabled");

    trip_c: cover property (oc_event);
    reg_c: cover property ($rose(in_regulation));
    stretch_c: cover property (low_side_gate && !pwm_low_req);
endmodule

bind boc_top boc_top_asserts #(
    .POR_DLY_CYCLES(POR_DLY_CYCLES),
    .SS_STEP_CYCLES(SS_STEP_CYCLES)
) boc_top_asserts_i (.*);

// ==== testbench/boc_fet_model.sv ====
/*
 * Behavioural power stage: low-side switch and programming resistor.
 * Assumes the device's DAC code is compared with the resistor code.
 */
`timescale 1ns/1ps
module boc_fet_model
    import boc_pkg::*;
(
    // From the device
    input wire logic              low_side_gate,
    input wire logic              trip_program_current,
    input wire logic [CODE_W-1:0] trip_code,
    // Bench settings
    input wire logic              short_on,
    input wire logic [CODE_W-1:0] res_code,
    // Comparator results
    output logic                  sample_met,
    output logic                  trip_cmp
);
    // All ones stands for a missing resistor, which never matches.
    assign sample_met = trip_program_current && res_code != 8'hFF
        && trip_code >= res_code;
    // A short only shows across the switch while it conducts.
    assign trip_cmp = low_side_gate && short_on;
endmodule

// ==== testbench/buck_overcurrent_hiccup_test.sv ====
/*
 * Testbench for boc_top: start-up, pulse stretching, hiccup retry and
 * shutdown with fresh sample, against the power-stage model.
 * Assumes shortened delay and step counts through the parameters.
 */
`timescale 1ns/1ps
module buck_overcurrent_hiccup_test;
    import boc_pkg::*;
    localparam int unsigned POR  = 50;
    localparam int unsigned STEP = 4;
    localparam int unsigned SS   = 64 * STEP;
    localparam int unsigned PER  = 40;
    localparam logic [7:0]  RES1 = 8'h03;
    localparam logic [7:0]  RES2 = 8'h05;
    logic       ref_clk;
    logic       rst_n;
    logic       ce;
    logic       enable_ok;
    logic       cycle_tick = 1'b0;
    logic       pwm_low_req = 1'b0;
    logic       pwm_high_req = 1'b0;
    logic       sample_met;
    logic       trip_cmp;
    logic       high_side_gate;
    logic       low_side_gate;
    logic       trip_program_current;
    logic [7:0] trip_code;
    logic [5:0] ss_ref_code;
    logic       osc_run;
    logic       overcurrent_guard_on;
    logic       in_regulation;
    logic       oc_event;
    logic       short_on;
    logic [7:0] res_code;
    int         low_w;
    int         ph = 0;
    int         error_cnt = 0;
    int         checks = 0;

    boc_top #(.POR_DLY_CYCLES(POR), .SS_STEP_CYCLES(STEP)) boc_top_i (.*);
    boc_fet_model boc_fet_model_i (.*);

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // Low phase first, then high; low_w of zero means a missing pulse.
    always @(posedge ref_clk) begin
        ph <= (ph == PER - 1) ? 0 : ph + 1;
        cycle_tick <= (ph == 0);
        pwm_low_req <= (ph < low_w);
        pwm_high_req <= (ph >= low_w) && (ph < PER - 2);
    end

    task automatic tick();
        @(posedge ref_clk);
        #1;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic t_startup();
        int n;
        repeat (3) tick();
        check({trip_program_current, low_side_gate}, 2'h2);
        for (n = 0; n < 8000 && overcurrent_guard_on !== 1'b1; n++) tick();
        check(trip_code, RES1);
        for (n = 0; n < 2 * SS && in_regulation !== 1'b1; n++) tick();
        check(n >= SS - 4 && n <= SS + 8, 1'b1);
    endtask

    // Leaves low_w at zero, so the next trip can only come from an
    // inserted pulse.
    task automatic t_stretch();
        int best;
        int run;
        int hits;
        int n;
        int w [2] = '{3, 0};
        foreach (w[i]) begin
            @(posedge ref_clk) low_w <= w[i];
            best = 0;
            run = 0;
            hits = 0;
            // Four periods settle the pattern; six more hold two forced pulses.
            for (n = 0; n < 10 * PER; n++) begin
                tick();
                run = low_side_gate ? run + 1 : 0;
                if (run > best) best = run;
                if (n >= 4 * PER && run == MIN_LS_CYC) hits++;
            end
            check(best >= MIN_LS_CYC, 1'b1);
            check(hits, 2);
        end
    endtask

    task automatic t_hiccup();
        int n;
        int bad;
        logic [7:0] code0;
        code0 = trip_code;
        @(posedge ref_clk) short_on <= 1'b1;
        for (n = 0; n < 4 * PER && oc_event !== 1'b1; n++) tick();
        check(oc_event, 1'b1);
        // Three retries in a row show the sequence does not give up.
        repeat (3) begin
            tick();
            bad = 0;
            for (n = 1; n < 4 * SS && oc_event !== 1'b1; n++) begin
                if (n < 2 * SS - 2 && (low_side_gate || high_side_gate))
                    bad++;
                tick();
            end
            check(bad, 0);
            check(n >= 2 * SS && n <= 3 * SS + PER, 1'b1);
        end
        check(trip_code, code0);
        @(posedge ref_clk) short_on <= 1'b0;
        for (n = 0; n < 4 * SS && in_regulation !== 1'b1; n++) tick();
        check(in_regulation, 1'b1);
    endtask

    task automatic t_enable();
        int n;
        @(posedge ref_clk) begin
            res_code <= RES2;
            enable_ok <= 1'b0;
            short_on <= 1'b1;
            low_w <= 30;
        end
        repeat (3) tick();
        check({low_side_gate, high_side_gate, osc_run}, 3'h0);
        @(posedge ref_clk) enable_ok <= 1'b1;
        for (n = 0; n < 9000 && oc_event !== 1'b1; n++) tick();
        check(oc_event, 1'b1);
        check(trip_code, RES2);
        @(posedge ref_clk) short_on <= 1'b0;
        for (n = 0; n < 4 * SS && in_regulation !== 1'b1; n++) tick();
        check(in_regulation, 1'b1);
    endtask

    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        enable_ok = 1'b1;
        short_on = 1'b0;
        res_code = RES1;
        low_w = 30;
        repeat (6) @(posedge ref_clk);
        #1;
        check({osc_run, oc_event, low_side_gate, trip_code}, 11'h000);
        @(posedge ref_clk) rst_n <= 1'b1;
        t_startup();
        t_stretch();
        t_hiccup();
        t_enable();
        tally_and_finish();
    end

    // The planned run stays near 10000 cycles.
    initial begin
        repeat (40000) @(posedge ref_clk);
        error_cnt++;
        tally_and_finish();
    end
endmodule
